// ===== inc/lcr_consts.svh
// Register offsets, field positions, timing counts and no-load thresholds for the line cycle block
`ifndef LCR_CONSTS_SVH
`define LCR_CONSTS_SVH
// Register indices; byte address is four times the index
`define LCR_IDX_LINE_ENERGY 8'h03
`define LCR_IDX_WAVE_SEL 8'h0d
`define LCR_IDX_NOLOAD_MODE 8'h0e
`define LCR_IDX_ACC_MODE 8'h0f
`define LCR_IDX_HALF_CYC 8'h12
`define LCR_IDX_VAR_GAIN 8'h1e
`define LCR_IDX_VAR_OFS 8'h21
`define LCR_IDX_IRQ_EN_LO 8'hd9
`define LCR_IDX_IRQ_EN_HI 8'hdb
`define LCR_IDX_IRQ_ST_LO 8'hdc
`define LCR_IDX_IRQ_ST_HI 8'hde
`define LCR_IDX_VAR_WAVE 8'he0
// Field positions
`define LCR_BIT_CYC_DONE 2
`define LCR_BIT_WAVE_EN 5
`define LCR_BIT_VAR_SIGN 4
`define LCR_BIT_VAR_IDLE 1
`define LCR_BIT_SIGN_DIR 5
`define LCR_BIT_INTEG_EN 6
`define LCR_WAVE_SEL_VAR 8'h04
// Timing and scaling
`define LCR_ACC_PERIOD 3'd5
`define LCR_GAIN_SHIFT 12
`define LCR_OFS_FRAC 8
// No-load thresholds, fractions of a 24-bit full scale
`define LCR_THR_1 24'h000272
`define LCR_THR_2 24'h000139
`define LCR_THR_3 24'h00009b
`endif

// ===== inc/lcr_pkg.sv
// Types shared by the line cycle and reactive power block
package lcr_pkg;
    typedef enum logic [1:0] {
        LCR_IDLE = 2'b00,
        LCR_ARM = 2'b01,
        LCR_RUN = 2'b11
    } lcr_state_t;
endpackage : lcr_pkg

// ===== logic/lcr_core.sv
// Line cycle active energy and reactive power datapath with Wishbone registers
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "lcr_consts.svh"

module lcr_core
    import lcr_pkg::*;
#(
    parameter int DW = 24
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic signed [DW-1:0] voltage_i,
    input wire logic signed [DW-1:0] current_shift_i,
    input wire logic signed [DW-1:0] active_power_i,
    input wire logic wave_tick_i,
    output logic integrator_en_o,
    output logic metering_interrupt_o,
    output logic signed [DW-1:0] var_wave_o,
    output logic var_wave_valid_o,
    output logic signed [DW-1:0] var_power_o,
    output logic var_accum_en_o
);

    // ************************************************
    // Registers and bus decode
    // ************************************************
    logic [7:0] wave_sel_reg;
    logic [7:0] no_load_mode_reg;
    logic [7:0] acc_mode_reg;
    logic [15:0] half_cycle_target_reg;
    logic [11:0] var_gain_reg;
    logic [15:0] var_ofs_reg;
    logic [7:0] irq_en_lo_reg;
    logic [7:0] irq_en_hi_reg;
    logic [7:0] irq_st_lo_reg;
    logic [7:0] irq_st_hi_reg;
    logic [DW-1:0] line_energy_reg;
    logic [DW-1:0] line_accum_reg;
    logic [15:0] half_count_reg;
    logic [2:0] tick_cnt_reg;
    logic v_sign_reg;
    logic v_sign_valid_reg;
    logic signed [DW-1:0] var_lpf_reg;
    logic signed [DW-1:0] var_power_reg;
    logic var_sign_reg;
    logic var_sign_valid_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    lcr_state_t state_reg;

    logic [7:0] idx;
    logic req;
    logic wr;
    logic wr_target;
    logic acc_tick;
    logic zero_cross;
    logic cycle_done;
    logic var_sign_event;
    logic var_idle;
    logic [DW-1:0] idle_thr;
    logic [DW-1:0] var_mag;
    logic signed [2*DW-1:0] inst_var;
    logic signed [DW-1:0] inst_var_top;
    logic signed [DW+12:0] gained;
    logic signed [DW+9:0] with_ofs;
    logic signed [DW-1:0] var_next;

    assign idx = wb_adr_i[9:2];
    assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr = req & wb_we_i;
    assign wr_target = wr && idx == `LCR_IDX_HALF_CYC;

    // Ack one cycle after the request; ack drops the cycle after it is given
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req;
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // Writable configuration, byte lanes honoured; unmapped writes are ignored
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wave_sel_reg <= 8'h00;
            no_load_mode_reg <= 8'h00;
            acc_mode_reg <= 8'h00;
            half_cycle_target_reg <= 16'hffff;
            var_gain_reg <= 12'h000;
            var_ofs_reg <= 16'h0000;
            irq_en_lo_reg <= 8'h00;
            irq_en_hi_reg <= 8'h00;
        end else if (wr) begin
            unique case (idx)
                `LCR_IDX_WAVE_SEL: if (wb_sel_i[0]) wave_sel_reg <= wb_dat_i[7:0];
                `LCR_IDX_NOLOAD_MODE: if (wb_sel_i[0]) no_load_mode_reg <= wb_dat_i[7:0];
                `LCR_IDX_ACC_MODE: if (wb_sel_i[0]) acc_mode_reg <= wb_dat_i[7:0];
                `LCR_IDX_HALF_CYC: begin
                    if (wb_sel_i[0]) half_cycle_target_reg[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) half_cycle_target_reg[15:8] <= wb_dat_i[15:8];
                end
                `LCR_IDX_VAR_GAIN: begin
                    if (wb_sel_i[0]) var_gain_reg[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) var_gain_reg[11:8] <= wb_dat_i[11:8];
                end
                `LCR_IDX_VAR_OFS: begin
                    if (wb_sel_i[0]) var_ofs_reg[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) var_ofs_reg[15:8] <= wb_dat_i[15:8];
                end
                `LCR_IDX_IRQ_EN_LO: if (wb_sel_i[0]) irq_en_lo_reg <= wb_dat_i[7:0];
                `LCR_IDX_IRQ_EN_HI: if (wb_sel_i[0]) irq_en_hi_reg <= wb_dat_i[7:0];
                default: ;
            endcase
        end
    end

    // Read mux, registered so data lines up with ack; unmapped reads give zero
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (req) begin
            unique case (idx)
                `LCR_IDX_LINE_ENERGY: rdata_reg <= {8'h00, line_energy_reg};
                `LCR_IDX_WAVE_SEL: rdata_reg <= {24'h000000, wave_sel_reg};
                `LCR_IDX_NOLOAD_MODE: rdata_reg <= {24'h000000, no_load_mode_reg};
                `LCR_IDX_ACC_MODE: rdata_reg <= {24'h000000, acc_mode_reg};
                `LCR_IDX_HALF_CYC: rdata_reg <= {16'h0000, half_cycle_target_reg};
                `LCR_IDX_VAR_GAIN: rdata_reg <= {20'h00000, var_gain_reg};
                `LCR_IDX_VAR_OFS: rdata_reg <= {16'h0000, var_ofs_reg};
                `LCR_IDX_IRQ_EN_LO: rdata_reg <= {24'h000000, irq_en_lo_reg};
                `LCR_IDX_IRQ_EN_HI: rdata_reg <= {24'h000000, irq_en_hi_reg};
                `LCR_IDX_IRQ_ST_LO: rdata_reg <= {24'h000000, irq_st_lo_reg};
                `LCR_IDX_IRQ_ST_HI: rdata_reg <= {24'h000000, irq_st_hi_reg};
                `LCR_IDX_VAR_WAVE: rdata_reg <= {8'h00, var_power_reg};
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // ************************************************
    // Line cycle active energy
    // ************************************************

    // Accumulation strobe every five clocks, shared with the ordinary energy path
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tick_cnt_reg <= 3'd0;
        end else if (tick_cnt_reg == `LCR_ACC_PERIOD - 3'd1) begin
            tick_cnt_reg <= 3'd0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 3'd1;
        end
    end
    assign acc_tick = tick_cnt_reg == `LCR_ACC_PERIOD - 3'd1;

    // Voltage sign history; first sample only primes it so reset is no crossing
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            v_sign_reg <= 1'b0;
            v_sign_valid_reg <= 1'b0;
        end else begin
            v_sign_reg <= voltage_i[DW-1];
            v_sign_valid_reg <= 1'b1;
        end
    end
    assign zero_cross = v_sign_valid_reg && v_sign_reg != voltage_i[DW-1];

    assign cycle_done = state_reg == LCR_RUN && zero_cross
        && half_count_reg + 16'd1 >= half_cycle_target_reg;

    // Sequencer: a target write arms, the next crossing starts counting
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= LCR_ARM;
            half_count_reg <= 16'h0000;
        end else if (wr_target) begin
            state_reg <= LCR_ARM;
            half_count_reg <= 16'h0000;
        end else begin
            unique case (state_reg)
                LCR_IDLE: state_reg <= LCR_ARM;
                LCR_ARM: if (zero_cross) state_reg <= LCR_RUN;
                LCR_RUN: begin
                    if (cycle_done) begin
                        half_count_reg <= 16'h0000;
                    end else if (zero_cross) begin
                        half_count_reg <= half_count_reg + 16'd1;
                    end
                end
                default: state_reg <= LCR_ARM;
            endcase
        end
    end

    // Running sum in the active energy LSB weight; result latched at completion
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            line_accum_reg <= '0;
            line_energy_reg <= '0;
        end else if (wr_target) begin
            line_accum_reg <= '0;
            line_energy_reg <= '0;
        end else if (state_reg == LCR_ARM && zero_cross) begin
            // Window opens on the starting crossing, so every result spans equal time
            line_accum_reg <= acc_tick ? active_power_i : '0;
        end else if (cycle_done) begin
            line_energy_reg <= line_accum_reg;
            line_accum_reg <= acc_tick ? active_power_i : '0;
        end else if (state_reg == LCR_RUN && acc_tick) begin
            line_accum_reg <= line_accum_reg + active_power_i;
        end
    end

    // ************************************************
    // Reactive power
    // ************************************************
    assign integrator_en_o = acc_mode_reg[`LCR_BIT_INTEG_EN];
    // Shifted current comes from the filter; its sign flips with the integrator
    // so the product keeps one sign convention for either setting
    assign inst_var = integrator_en_o ? -(voltage_i * current_shift_i)
                                      : voltage_i * current_shift_i;
    assign inst_var_top = inst_var[2*DW-2 -: DW];

    // Gain, then offset with eight fraction bits
    assign gained = (inst_var_top * $signed({1'b0, 13'h1000}))
        + (inst_var_top * $signed(var_gain_reg));
    assign with_ofs = $signed(gained[DW+12:`LCR_GAIN_SHIFT - `LCR_OFS_FRAC])
        + $signed({{(DW-6){var_ofs_reg[15]}}, var_ofs_reg});
    assign var_next = with_ofs[DW+7:`LCR_OFS_FRAC];

    // First-order low-pass extracting the dc term; the tap is a fixed trade
    // of ripple against settling time
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            var_lpf_reg <= '0;
            var_power_reg <= '0;
        end else if (acc_tick) begin
            var_lpf_reg <= var_lpf_reg + ((var_next - var_lpf_reg) >>> 4);
            var_power_reg <= var_lpf_reg;
        end
    end
    assign var_power_o = var_power_reg;

    // Waveform samples at the externally set rate when selected and enabled
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            var_wave_o <= '0;
            var_wave_valid_o <= 1'b0;
        end else begin
            var_wave_valid_o <= 1'b0;
            if (wave_tick_i && wave_sel_reg == `LCR_WAVE_SEL_VAR
                && irq_en_hi_reg[`LCR_BIT_WAVE_EN]) begin
                var_wave_o <= var_power_reg;
                var_wave_valid_o <= 1'b1;
            end
        end
    end

    // Sign tracking on each filtered sample
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            var_sign_reg <= 1'b0;
            var_sign_valid_reg <= 1'b0;
        end else if (acc_tick) begin
            var_sign_reg <= var_power_reg[DW-1];
            var_sign_valid_reg <= 1'b1;
        end
    end
    assign var_sign_event = acc_tick && var_sign_valid_reg
        && (acc_mode_reg[`LCR_BIT_SIGN_DIR]
            ? (var_sign_reg && !var_power_reg[DW-1])
            : (!var_sign_reg && var_power_reg[DW-1]));

    // No-load compare on multiplier magnitude
    assign var_mag = inst_var_top[DW-1] ? -inst_var_top : inst_var_top;
    always_comb begin
        unique case (no_load_mode_reg[3:2])
            2'b01: idle_thr = `LCR_THR_1;
            2'b10: idle_thr = `LCR_THR_2;
            2'b11: idle_thr = `LCR_THR_3;
            default: idle_thr = '0;
        endcase
    end
    assign var_idle = no_load_mode_reg[3:2] != 2'b00 && var_mag < idle_thr;
    assign var_accum_en_o = ~var_idle;

    // ************************************************
    // Status flags and interrupt
    // ************************************************

    // Write one to clear; a set in the same cycle wins
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_st_lo_reg <= 8'h00;
            irq_st_hi_reg <= 8'h00;
        end else begin
            if (wr && idx == `LCR_IDX_IRQ_ST_LO && wb_sel_i[0]) begin
                irq_st_lo_reg <= irq_st_lo_reg & ~wb_dat_i[7:0];
            end
            if (wr && idx == `LCR_IDX_IRQ_ST_HI && wb_sel_i[0]) begin
                irq_st_hi_reg <= irq_st_hi_reg & ~wb_dat_i[7:0];
            end
            if (var_sign_event) irq_st_lo_reg[`LCR_BIT_VAR_SIGN] <= 1'b1;
            if (var_idle) irq_st_lo_reg[`LCR_BIT_VAR_IDLE] <= 1'b1;
            if (cycle_done) irq_st_hi_reg[`LCR_BIT_CYC_DONE] <= 1'b1;
        end
    end

    // Level output, held until the enabled flag is cleared
    assign metering_interrupt_o = |(irq_st_lo_reg & irq_en_lo_reg
        & 8'h12) | |(irq_st_hi_reg & irq_en_hi_reg & 8'h04);

endmodule : lcr_core

// ===== verif/lcr_core_monitor.sv
// Concurrent checks on the ports of the line cycle block
`timescale 1ns/1ps
module lcr_core_monitor
    import lcr_pkg::*;
#(
    parameter int DW = 24
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic signed [DW-1:0] voltage_i,
    input wire logic signed [DW-1:0] current_shift_i,
    input wire logic signed [DW-1:0] active_power_i,
    input wire logic wave_tick_i,
    input wire logic integrator_en_o,
    input wire logic metering_interrupt_o,
    input wire logic signed [DW-1:0] var_wave_o,
    input wire logic var_wave_valid_o,
    input wire logic signed [DW-1:0] var_power_o,
    input wire logic var_accum_en_o
);
    // ****************
    // Properties
    // ****************
    default clocking dc @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    // Ack is one cycle after the taking edge and lasts one cycle
    a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
    // Read data holds while the bus is idle, so a slow master still sees it
    a_dat_hold: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
        else $error("read data moved");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[9:2] == 8'h40
        |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    // Interrupt is sticky: only a register write can take it down
    a_irq_sticky: assert property ($fell(metering_interrupt_o)
        |-> $past(wb_cyc_i && wb_stb_i && wb_we_i)) else $error("irq fell unasked");
    a_integ_write: assert property ($changed(integrator_en_o)
        |-> $past(wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i[9:2] == 8'h0f))
        else $error("integrator moved unasked");
    a_wave_hold: assert property ($changed(var_wave_o) |-> var_wave_valid_o)
        else $error("sample moved without valid");
    a_valid_pulse: assert property (var_wave_valid_o |=> !var_wave_valid_o)
        else $error("valid too long");
endmodule : lcr_core_monitor

bind lcr_core lcr_core_monitor #(.DW(DW)) mon_u (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .voltage_i(voltage_i),
    .current_shift_i(current_shift_i), .active_power_i(active_power_i),
    .wave_tick_i(wave_tick_i), .integrator_en_o(integrator_en_o),
    .metering_interrupt_o(metering_interrupt_o), .var_wave_o(var_wave_o),
    .var_wave_valid_o(var_wave_valid_o), .var_power_o(var_power_o),
    .var_accum_en_o(var_accum_en_o)
);

// ===== verif/lcr_front_model.sv
// Line front-end model: square voltage, shifted current, steady power, sample strobe
`timescale 1ns/1ps
module lcr_front_model #(
    parameter int HALF = 20,
    parameter int TICK = 40
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic integ_i,
    input wire logic signed [23:0] cur_amp_i,
    input wire logic signed [23:0] pwr_i,
    output logic signed [23:0] voltage_o,
    output logic signed [23:0] current_o,
    output logic signed [23:0] power_o,
    output logic tick_o
);
    int ph_cnt;
    int tk_cnt;
    // ****************
    // Waveforms
    // ****************
    // Hard square so every crossing lands on a known clock
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ph_cnt <= 0;
            voltage_o <= 24'sh100000;
        end else if (ph_cnt == HALF - 1) begin
            ph_cnt <= 0;
            voltage_o <= -voltage_o;
        end else begin
            ph_cnt <= ph_cnt + 1;
        end
    end
    // One-clock sample strobe
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tk_cnt <= 0;
        end else begin
            tk_cnt <= (tk_cnt == TICK - 1) ? 0 : tk_cnt + 1;
        end
    end
    assign tick_o = (tk_cnt == TICK - 1);
    // Shift filter output: its sign turns over with the integrator, so the
    // reactive sign seen after the block's correction follows cur_amp_i
    assign current_o = (voltage_o[23] ^ integ_i) ? -cur_amp_i : cur_amp_i;
    assign power_o = pwr_i;
endmodule : lcr_front_model

// ===== verif/tb_line_cycle_and_reactive_power.sv
// Self-checking bench for the line cycle and reactive power block
`timescale 1ns/1ps
module tb_line_cycle_and_reactive_power;
    import lcr_pkg::*;
    localparam int HALF = 20;
    localparam int TGT = 8;
    typedef struct {logic [7:0] idx; logic [31:0] wd; logic [31:0] ex;} lcr_row_t;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [31:0] adr = 32'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic ack, tick, integ, irq, wvalid, acc_en;
    logic signed [23:0] volt, cur, pwr, wave, vpow;
    logic signed [23:0] cur_amp = 24'sh0;
    int err_count = 0;
    int cmp_count = 0;
    // Register widths: written all ones, read back masked
    lcr_row_t rows [8] = '{'{8'h0d, '1, 32'hff}, '{8'h0e, '1, 32'hff}, '{8'h0f, '1, 32'hff},
        '{8'h12, '1, 32'hffff}, '{8'h1e, '1, 32'hfff}, '{8'h21, '1, 32'hffff},
        '{8'hd9, '1, 32'hff}, '{8'h40, '1, 32'h0}};

    lcr_core #(.DW(24)) dut_u (.mclk_i(mclk), .resetn_i(resetn), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_ack_o(ack), .voltage_i(volt), .current_shift_i(cur),
        .active_power_i(pwr), .wave_tick_i(tick), .integrator_en_o(integ),
        .metering_interrupt_o(irq), .var_wave_o(wave), .var_wave_valid_o(wvalid),
        .var_power_o(vpow), .var_accum_en_o(acc_en));
    lcr_front_model #(.HALF(HALF), .TICK(40)) front_u (.mclk_i(mclk), .resetn_i(resetn),
        .integ_i(integ), .cur_amp_i(cur_amp), .pwr_i(24'sh000100), .voltage_o(volt),
        .current_o(cur),
        .power_o(pwr), .tick_o(tick));

    // ****************
    // Tasks
    // ****************
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        cmp_count++;
        if (got !== ex) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    // Classic cycle: hold everything until ack is sampled, then release
    task automatic xfer(input logic [7:0] idx, input logic w, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        @(posedge mclk);
        adr <= {22'h0, idx, 2'b00};
        we <= w;
        wdat <= d;
        cyc <= 1'b1;
        stb <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        chk("bus_ack", 1, n < 50);
    endtask : xfer
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] q;
        xfer(idx, 1'b1, d, q);
    endtask : wr
    task automatic wait_irq(input int lim, output int n);
        n = 0;
        while (irq !== 1'b1 && n < lim) begin
            @(posedge mclk);
            n++;
        end
    endtask : wait_irq
    task automatic end_of_test();
        if (err_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    initial begin
        forever #20 mclk = ~mclk;
    end
    // Whole run is about 6k cycles; give it ample margin
    initial begin
        #(40 * 40000);
        err_count++;
        end_of_test();
    end

    initial begin
        logic [31:0] q, e1;
        int n, c;
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        xfer(8'h12, 1'b0, 0, q);
        chk("target_reset", 32'hffff, q);
        foreach (rows[i]) begin
            wr(rows[i].idx, rows[i].wd);
            xfer(rows[i].idx, 1'b0, 0, q);
            chk("reg_readback", rows[i].ex, q);
            wr(rows[i].idx, 32'h0);
        end
        // Line cycle: armed at the write, then TGT crossings
        wr(8'hdb, 32'h04);
        wr(8'h12, TGT);
        wr(8'hde, 32'hff);
        xfer(8'h03, 1'b0, 0, q);
        chk("energy_cleared", 0, q);
        wait_irq(400, n);
        chk("done_time", 1, n >= TGT*HALF-12 && n <= (TGT+1)*HALF+4);
        xfer(8'hde, 1'b0, 0, q);
        chk("done_flag", 1, q[2]);
        chk("done_irq", 1, irq);
        xfer(8'h03, 1'b0, 0, e1);
        chk("energy_nonzero", 1, e1 != 0);
        chk("energy_value", TGT * HALF / 5 * 256, e1);
        wr(8'hde, 32'h04);
        @(posedge mclk);
        chk("irq_cleared", 0, irq);
        wait_irq(400, n);
        chk("restart_time", 1, n >= TGT*HALF-15 && n <= TGT*HALF);
        xfer(8'h03, 1'b0, 0, q);
        chk("energy_repeat", e1, q);
        wr(8'hdb, 32'h0);
        // Sign change in both directions and both integrator settings
        for (int d = 0; d < 2; d++) begin
            cur_amp <= d ? -24'sh100000 : 24'sh100000;
            wr(8'h0f, d ? 32'h60 : 32'h0);
            repeat (1500) @(posedge mclk);
            chk("integrator", d, integ);
            chk("var_sign", d, vpow[23]);
            wr(8'hdc, 32'hff);
            wr(8'hd9, 32'h10);
            cur_amp <= -cur_amp;
            wait_irq(3000, n);
            xfer(8'hdc, 1'b0, 0, q);
            chk("sign_flag", 1, q[4]);
            wr(8'hd9, 32'h0);
        end
        // No-load with zero product, every threshold choice
        cur_amp <= 24'sh0;
        repeat (1500) @(posedge mclk);
        for (int s = 3; s >= 0; s--) begin
            wr(8'h0e, s << 2);
            wr(8'hdc, 32'hff);
            wr(8'hd9, 32'h02);
            repeat (20) @(posedge mclk);
            xfer(8'hdc, 1'b0, 0, q);
            chk("idle_flag", s != 0, q[1]);
            chk("idle_irq", s != 0, irq);
            chk("accum_en", s == 0, acc_en);
            wr(8'hd9, 32'h0);
        end
        // Reactive samples only while enabled, with the reactive waveform selected throughout
        wr(8'h0d, 32'h04);
        for (int w = 0; w < 2; w++) begin
            wr(8'hdb, w ? 32'h0 : 32'h20);
            c = 0;
            repeat (400) begin
                @(posedge mclk);
                if (wvalid === 1'b1) c++;
            end
            chk("wave_count", 1, w ? c == 0 : (c >= 9 && c <= 11));
        end
        end_of_test();
    end
endmodule : tb_line_cycle_and_reactive_power
